// file: hdl/lin_brk_pkg.sv
package lin_brk_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_IDLEC, TX_BREAK, TX_BSTOP, TX_DATA} tx_state_t;
    typedef enum logic {RX_WAIT, RX_BUSY} rx_state_t;
    // Register indices on the plain register port.
    localparam logic [3:0] A_CTRL1 = 4'h0;
    localparam logic [3:0] A_CTRL2 = 4'h1;
    localparam logic [3:0] A_CTRL3 = 4'h2;
    localparam logic [3:0] A_STAT  = 4'h3;
    localparam logic [3:0] A_DATA  = 4'h4;
    localparam logic [3:0] A_BAUD  = 4'h5;
    localparam logic [3:0] A_HLEN  = 4'h6;
    localparam logic [3:0] A_MASK  = 4'h7;
    // Field positions.
    localparam int B_WLEN   = 4;
    localparam int B_BRK    = 0;
    localparam int B_MUTE   = 1;
    localparam int B_TXEN   = 3;
    localparam int B_LINSLV = 5;
    localparam int B_LINEN  = 6;
    localparam int F_RXF    = 0;
    localparam int F_HDET   = 1;
    localparam int F_HERR   = 2;
    localparam int S_TXBUSY = 3;
    // Reset values.
    localparam logic [7:0] BAUD_RST = 8'h1F;
    localparam logic [7:0] ZERO8    = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h0;
    // Bit-time figures.
    localparam logic [3:0] LEN_BRK_M0  = 4'hA;
    localparam logic [3:0] LEN_BRK_M1  = 4'hB;
    localparam logic [3:0] LEN_BRK_LIN = 4'hD;
    localparam logic [3:0] FRAME_M0    = 4'hA;
    localparam logic [3:0] FRAME_M1    = 4'hB;
    localparam logic [3:0] SUB_LAST    = 4'hF;
    localparam logic [3:0] SUB_MID     = 4'h7;
    localparam logic [3:0] BRK_DET_BITS = 4'hB;
    localparam logic [7:0] HDR_MAX_BITS = 8'h39;
endpackage

// file: hdl/lin_sci_break_and_header_mute.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module lin_sci_break_and_header_mute #(
    parameter logic [7:0] BAUD_RESET = lin_brk_pkg::BAUD_RST,
    parameter int         HDR_LIMIT  = 57
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RESET,
    input  wire logic       CE,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       RXD,
    output logic            TXD,
    output logic            IRQ
);
    if (HDR_LIMIT <= 11 || HDR_LIMIT > 250) begin : g_chk
        $error("HDR_LIMIT out of range");
    end

    localparam logic [7:0] HDR_LIM = 8'(HDR_LIMIT);

    lin_brk_pkg::tx_state_t tx_st_q;
    lin_brk_pkg::rx_state_t rx_st_q;
    logic [7:0]  baud_q, baud_cnt_q, tdr_q, rdr_q, hlen_q, rdata_q, low_cnt_q, hdr_bits_q;
    logic        wlen_q, sbk_q, rwu_q, te_q, linen_q, linslv_q;
    logic [2:0]  flags_q, snap_q, mask_q, flag_set;
    logic        arm_q, brk_req_q, idle_req_q, tx_full_q, txd_q;
    logic [3:0]  tx_sub_q, tx_cnt_q, rx_sub_q, rx_idx_q, hdr_sub_q;
    logic [10:0] tx_sh_q;
    logic        s1_q, s2_q, s3_q, rx_lvl_q, rx_prev_q;
    logic        hdr_act_q, hdr_byte_q;
    logic        tick16, bit_end, rx_done, brk_det, hdr_to, hdr_ok, data_rd, stat_rd;
    logic [3:0]  brk_len, frame_len;
    logic        lin_master;

    assign stat_rd    = CE && RD && ADDR == lin_brk_pkg::A_STAT;
    assign data_rd    = CE && RD && ADDR == lin_brk_pkg::A_DATA;
    assign lin_master = linen_q && !wlen_q;
    assign frame_len  = wlen_q ? lin_brk_pkg::FRAME_M1 : lin_brk_pkg::FRAME_M0;
    assign brk_len    = lin_master ? lin_brk_pkg::LEN_BRK_LIN :
                        (wlen_q ? lin_brk_pkg::LEN_BRK_M1 : lin_brk_pkg::LEN_BRK_M0);

    // Oversample tick, sixteen per bit time.
    assign tick16  = CE && baud_cnt_q == baud_q;
    assign bit_end = tick16 && tx_sub_q == lin_brk_pkg::SUB_LAST;

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            baud_cnt_q <= lin_brk_pkg::ZERO8;
        end else if (CE) begin
            baud_cnt_q <= tick16 ? lin_brk_pkg::ZERO8 : baud_cnt_q + 8'h01;
        end
    end

    // Control registers written by software.
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            wlen_q   <= 1'b0;
            sbk_q    <= 1'b0;
            te_q     <= 1'b0;
            linen_q  <= 1'b0;
            linslv_q <= 1'b0;
            baud_q   <= BAUD_RESET;
            mask_q   <= lin_brk_pkg::MASK_RST;
        end else if (CE && WR) begin
            unique case (ADDR)
                lin_brk_pkg::A_CTRL1: wlen_q <= WDATA[lin_brk_pkg::B_WLEN];
                lin_brk_pkg::A_CTRL2: begin
                    sbk_q <= WDATA[lin_brk_pkg::B_BRK];
                    te_q  <= WDATA[lin_brk_pkg::B_TXEN];
                end
                lin_brk_pkg::A_CTRL3: begin
                    linen_q  <= WDATA[lin_brk_pkg::B_LINEN];
                    linslv_q <= WDATA[lin_brk_pkg::B_LINSLV];
                end
                lin_brk_pkg::A_BAUD: baud_q <= WDATA;
                lin_brk_pkg::A_MASK: mask_q <= WDATA[2:0];
                default: ;
            endcase
        end
    end

    // Mute bit: software write wins, a good header wakes, a timeout leaves it as is.
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            rwu_q <= 1'b0;
        end else if (CE) begin
            if (WR && ADDR == lin_brk_pkg::A_CTRL2) begin
                rwu_q <= WDATA[lin_brk_pkg::B_MUTE];
            end else if (hdr_ok) begin
                rwu_q <= 1'b0;
            end
        end
    end

    // Requests: a rising send-break write and a transmit enable off-to-on write.
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            brk_req_q  <= 1'b0;
            idle_req_q <= 1'b0;
            tx_full_q  <= 1'b0;
            tdr_q      <= lin_brk_pkg::ZERO8;
        end else if (CE) begin
            if (WR && ADDR == lin_brk_pkg::A_CTRL2 && WDATA[lin_brk_pkg::B_BRK] && !sbk_q) begin
                brk_req_q <= 1'b1;
            end else if (tx_st_q != lin_brk_pkg::TX_BREAK && tx_st_q != lin_brk_pkg::TX_IDLEC &&
                         tx_st_q != lin_brk_pkg::TX_BSTOP && (tx_st_q == lin_brk_pkg::TX_IDLE) &&
                         te_q && !idle_req_q && (brk_req_q || sbk_q)) begin
                brk_req_q <= 1'b0;
            end
            if (WR && ADDR == lin_brk_pkg::A_CTRL2 && WDATA[lin_brk_pkg::B_TXEN] && !te_q) begin
                idle_req_q <= 1'b1;
            end else if (tx_st_q == lin_brk_pkg::TX_IDLE && te_q) begin
                idle_req_q <= 1'b0;
            end
            if (WR && ADDR == lin_brk_pkg::A_DATA) begin
                tx_full_q <= 1'b1;
                tdr_q     <= WDATA;
            end else if (tx_st_q == lin_brk_pkg::TX_IDLE && te_q && !idle_req_q && !brk_req_q && !sbk_q) begin
                tx_full_q <= 1'b0;
            end
        end
    end

    // Transmitter: idle ahead of break ahead of data.
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            tx_st_q  <= lin_brk_pkg::TX_IDLE;
            tx_sub_q <= 4'h0;
            tx_cnt_q <= 4'h0;
            tx_sh_q  <= 11'h7FF;
            txd_q    <= 1'b1;
        end else if (CE) begin
            if (tx_st_q == lin_brk_pkg::TX_IDLE) begin
                tx_sub_q <= 4'h0;
            end else if (tick16) begin
                tx_sub_q <= tx_sub_q + 4'h1;
            end
            unique case (tx_st_q)
                lin_brk_pkg::TX_IDLE: begin
                    txd_q <= 1'b1;
                    if (te_q && idle_req_q) begin
                        tx_st_q  <= lin_brk_pkg::TX_IDLEC;
                        tx_cnt_q <= frame_len;
                    end else if (te_q && (brk_req_q || sbk_q)) begin
                        tx_st_q  <= lin_brk_pkg::TX_BREAK;
                        tx_cnt_q <= brk_len;
                        txd_q    <= 1'b0;
                    end else if (te_q && tx_full_q) begin
                        tx_st_q  <= lin_brk_pkg::TX_DATA;
                        tx_cnt_q <= frame_len;
                        tx_sh_q  <= {2'b11, tdr_q, 1'b0};
                        txd_q    <= 1'b0;
                    end
                end
                lin_brk_pkg::TX_IDLEC: begin
                    if (bit_end) begin
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                        if (tx_cnt_q == 4'h1) begin
                            tx_st_q <= lin_brk_pkg::TX_IDLE;
                        end
                    end
                end
                lin_brk_pkg::TX_BREAK: begin
                    if (bit_end) begin
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                        if (tx_cnt_q == 4'h1) begin
                            tx_st_q <= lin_brk_pkg::TX_BSTOP;
                            txd_q   <= 1'b1;
                        end
                    end
                end
                lin_brk_pkg::TX_BSTOP: begin
                    if (bit_end) begin
                        if (sbk_q) begin
                            tx_st_q  <= lin_brk_pkg::TX_BREAK;
                            tx_cnt_q <= brk_len;
                            txd_q    <= 1'b0;
                        end else begin
                            tx_st_q <= lin_brk_pkg::TX_IDLE;
                        end
                    end
                end
                lin_brk_pkg::TX_DATA: begin
                    if (bit_end) begin
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                        txd_q    <= tx_sh_q[1];
                        if (tx_cnt_q == 4'h1) begin
                            tx_st_q <= lin_brk_pkg::TX_IDLE;
                            txd_q   <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Line input: three stages, a change counts once stages two and three agree.
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            s1_q      <= 1'b1;
            s2_q      <= 1'b1;
            s3_q      <= 1'b1;
            rx_lvl_q  <= 1'b1;
            rx_prev_q <= 1'b1;
        end else if (CE) begin
            s1_q      <= RXD;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            rx_prev_q <= rx_lvl_q;
            if (s2_q == s3_q) begin
                rx_lvl_q <= s3_q;
            end
        end
    end

    // Receiver: start on a falling edge, sample mid-bit at oversample seven.
    assign rx_done = rx_st_q == lin_brk_pkg::RX_BUSY && tick16 && rx_sub_q == lin_brk_pkg::SUB_MID &&
                     rx_idx_q == frame_len - 4'h1 && rx_lvl_q;

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            rx_st_q  <= lin_brk_pkg::RX_WAIT;
            rx_sub_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rdr_q    <= lin_brk_pkg::ZERO8;
        end else if (CE) begin
            unique case (rx_st_q)
                lin_brk_pkg::RX_WAIT: begin
                    rx_sub_q <= 4'h0;
                    rx_idx_q <= 4'h0;
                    if (rx_prev_q && !rx_lvl_q) begin
                        rx_st_q <= lin_brk_pkg::RX_BUSY;
                    end
                end
                lin_brk_pkg::RX_BUSY: begin
                    if (tick16) begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                        if (rx_sub_q == lin_brk_pkg::SUB_MID) begin
                            rx_idx_q <= rx_idx_q + 4'h1;
                            if ((rx_idx_q == 4'h0 && rx_lvl_q) || rx_idx_q == frame_len - 4'h1) begin
                                rx_st_q <= lin_brk_pkg::RX_WAIT;
                            end
                            if (rx_idx_q >= 4'h1 && rx_idx_q <= 4'h8) begin
                                rdr_q <= {rx_lvl_q, rdr_q[7:1]};
                            end
                        end
                    end
                end
            endcase
        end
    end

    // LIN slave header tracking from break detection to the identifier byte.
    assign brk_det = tick16 && !rx_lvl_q && low_cnt_q == {lin_brk_pkg::BRK_DET_BITS, 4'h0} - 8'h01;
    assign hdr_to  = hdr_act_q && hdr_bits_q > HDR_LIM;
    assign hdr_ok  = hdr_act_q && !hdr_to && rx_done && hdr_byte_q;

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            low_cnt_q <= lin_brk_pkg::ZERO8;
        end else if (CE) begin
            if (rx_lvl_q) begin
                low_cnt_q <= lin_brk_pkg::ZERO8;
            end else if (tick16 && low_cnt_q != {lin_brk_pkg::BRK_DET_BITS, 4'h0}) begin
                low_cnt_q <= low_cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            hdr_act_q  <= 1'b0;
            hdr_sub_q  <= 4'h0;
            hdr_bits_q <= lin_brk_pkg::ZERO8;
            hdr_byte_q <= 1'b0;
        end else if (CE) begin
            if (brk_det && linen_q && linslv_q) begin
                hdr_act_q  <= 1'b1;
                hdr_sub_q  <= 4'h0;
                hdr_bits_q <= {4'h0, lin_brk_pkg::BRK_DET_BITS};
                hdr_byte_q <= 1'b0;
            end else if (hdr_to || hdr_ok) begin
                hdr_act_q <= 1'b0;
            end else if (hdr_act_q) begin
                if (rx_done) begin
                    hdr_byte_q <= 1'b1;
                end
                if (tick16) begin
                    hdr_sub_q <= hdr_sub_q + 4'h1;
                    if (hdr_sub_q == lin_brk_pkg::SUB_LAST) begin
                        hdr_bits_q <= hdr_bits_q + 8'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            hlen_q <= lin_brk_pkg::ZERO8;
        end else if (CE) begin
            if (hdr_to) begin
                hlen_q <= lin_brk_pkg::ZERO8;
            end else if (hdr_ok) begin
                hlen_q <= hdr_bits_q;
            end
        end
    end

    // Sticky flags: a status read arms, the next data read clears what it saw; a new set wins.
    always_comb begin
        flag_set               = 3'h0;
        flag_set[lin_brk_pkg::F_RXF]  = rx_done && !rwu_q;
        flag_set[lin_brk_pkg::F_HDET] = hdr_ok;
        flag_set[lin_brk_pkg::F_HERR] = hdr_to;
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            flags_q <= 3'h0;
            snap_q  <= 3'h0;
            arm_q   <= 1'b0;
        end else if (CE) begin
            flags_q <= flag_set | (flags_q & ~((data_rd && arm_q) ? snap_q : 3'h0));
            if (stat_rd) begin
                arm_q  <= 1'b1;
                snap_q <= flags_q;
            end else if (data_rd) begin
                arm_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            rdata_q <= lin_brk_pkg::ZERO8;
        end else if (CE) begin
            rdata_q <= lin_brk_pkg::ZERO8;
            if (RD) begin
                unique case (ADDR)
                    lin_brk_pkg::A_CTRL1: rdata_q[lin_brk_pkg::B_WLEN] <= wlen_q;
                    lin_brk_pkg::A_CTRL2: rdata_q <= 8'(te_q << lin_brk_pkg::B_TXEN) | 8'(rwu_q << lin_brk_pkg::B_MUTE) |
                                                     8'(sbk_q << lin_brk_pkg::B_BRK);
                    lin_brk_pkg::A_CTRL3: rdata_q <= 8'(linen_q << lin_brk_pkg::B_LINEN) |
                                                     8'(linslv_q << lin_brk_pkg::B_LINSLV);
                    lin_brk_pkg::A_STAT:  rdata_q <= {4'h0, tx_st_q != lin_brk_pkg::TX_IDLE, flags_q};
                    lin_brk_pkg::A_DATA:  rdata_q <= rdr_q;
                    lin_brk_pkg::A_BAUD:  rdata_q <= baud_q;
                    lin_brk_pkg::A_HLEN:  rdata_q <= hlen_q;
                    lin_brk_pkg::A_MASK:  rdata_q <= {5'h00, mask_q};
                    default: ;
                endcase
            end
        end
    end

    assign RDATA = rdata_q;
    assign TXD   = txd_q;
    assign IRQ   = |(flags_q & mask_q);

    // Checks.
    logic [3:0] brk_seen_q;
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            brk_seen_q <= 4'h0;
        end else if (CE) begin
            if (tx_st_q != lin_brk_pkg::TX_BREAK) begin
                brk_seen_q <= 4'h0;
            end else if (bit_end) begin
                brk_seen_q <= brk_seen_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET || !CE);

    sequence s_status_read; stat_rd; endsequence
    sequence s_data_read; data_rd && !rx_done; endsequence

    chk_break_length: assert property ($rose(tx_st_q == lin_brk_pkg::TX_BSTOP) |-> $past(brk_seen_q) + 4'h1 == brk_len)
        else $error("break length wrong");
    chk_break_stop_high: assert property (tx_st_q == lin_brk_pkg::TX_BSTOP |-> TXD)
        else $error("break stop bit not high");
    chk_no_extra_break: assert property (tx_st_q == lin_brk_pkg::TX_BSTOP && bit_end && !sbk_q |=> tx_st_q == lin_brk_pkg::TX_IDLE)
        else $error("extra break after clear");
    chk_idle_first: assert property (tx_st_q == lin_brk_pkg::TX_IDLE && te_q && idle_req_q |=> tx_st_q == lin_brk_pkg::TX_IDLEC && TXD)
        else $error("idle not sent first");
    chk_timeout_flag: assert property (hdr_to |=> flags_q[lin_brk_pkg::F_HERR] && (IRQ || !mask_q[lin_brk_pkg::F_HERR]))
        else $error("header error not raised");
    chk_mute_kept: assert property (hdr_to && rwu_q && !WR |=> rwu_q)
        else $error("timeout woke receiver");
    chk_detect_untouched: assert property (hdr_to && !flags_q[lin_brk_pkg::F_HDET] |=> !flags_q[lin_brk_pkg::F_HDET])
        else $error("detect flag moved on timeout");
    chk_length_zero: assert property (hdr_to |=> hlen_q == lin_brk_pkg::ZERO8)
        else $error("header length not zero");
    chk_flag_clear: assert property (s_data_read ##0 (arm_q && snap_q[lin_brk_pkg::F_RXF]) |=> !flags_q[lin_brk_pkg::F_RXF])
        else $error("flags not cleared");
    chk_status_arms: assert property (s_status_read |=> arm_q)
        else $error("status read did not arm clear");
    chk_rx_full: assert property (rx_done && !rwu_q |=> flags_q[lin_brk_pkg::F_RXF] && rdr_q == $past(rdr_q))
        else $error("receive full not set");
    chk_mute_write: assert property (WR && ADDR == lin_brk_pkg::A_CTRL2 && WDATA[lin_brk_pkg::B_MUTE] |=> rwu_q)
        else $error("mute write lost");
endmodule // lin_sci_break_and_header_mute

// file: test/lin_remote_node.sv
`timescale 1ns/1ps
module lin_remote_node #(
    parameter int BIT = 16
) (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    int run_q    = 0;
    int last_low = 0;
    int n_brk    = 0;
    // Measures each low stretch on the line from the block.
    always @(posedge clk) begin
        if (txd === 1'b0) begin
            run_q <= run_q + 1;
        end else if (run_q != 0) begin
            last_low <= run_q;
            n_brk    <= n_brk + 1;
            run_q    <= 0;
        end
    end
    task automatic hold(input logic v, input int bits);
        rxd <= v;
        repeat (bits * BIT) @(posedge clk);
    endtask
    // Start bit, eight data bits from bit zero up, then the line high for two bit times.
    task automatic send_byte(input logic [7:0] b);
        hold(1'b0, 1);
        for (int i = 0; i < 8; i++) begin
            hold(b[i], 1);
        end
        hold(1'b1, 2);
    endtask
    initial rxd = 1'b1;
endmodule // lin_remote_node

// file: test/tb_lin_sci_break_and_header_mute.sv
`timescale 1ns/1ps
module tb_lin_sci_break_and_header_mute;
    logic       clk   = 1'b0;
    logic       rst   = 1'b1;
    logic [3:0] addr  = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic [7:0] rdata;
    logic       rxd;
    logic       txd;
    logic       irq;
    logic [7:0] v;
    logic [7:0] b;
    int         n_fail  = 0;
    int         checked = 0;
    int         cyc     = 0;
    int         k;
    always #50 clk = ~clk;
    lin_sci_break_and_header_mute #(.BAUD_RESET(8'h00), .HDR_LIMIT(57)) dut_u (
        .CORE_CLK(clk), .RESET(rst), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .RXD(rxd), .TXD(txd), .IRQ(irq));
    lin_remote_node node_u (.clk(clk), .txd(txd), .rxd(rxd));
    task automatic close_out();
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrt(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdt(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
    // Idle request, then a break pulse with nothing between them.
    task automatic brk(input logic [7:0] c1, input logic [7:0] c3, input int bits);
        wrt(lin_brk_pkg::A_CTRL1, c1);
        wrt(lin_brk_pkg::A_CTRL3, c3);
        wrt(lin_brk_pkg::A_CTRL2, 8'h00);
        wrt(lin_brk_pkg::A_CTRL2, 8'h08);
        k = node_u.n_brk;
        wrt(lin_brk_pkg::A_CTRL2, 8'h09);
        wrt(lin_brk_pkg::A_CTRL2, 8'h08);
        repeat (128) @(posedge clk);
        chk(txd, 1'b1);
        repeat (700) @(posedge clk);
        chk(node_u.n_brk - k, 1);
        chk(node_u.last_low, bits * 16);
        chk(txd, 1'b1);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'h0A76F21B));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        chk({txd, irq}, 2'b10);
        rdt(lin_brk_pkg::A_BAUD);
        chk(v, 8'h00);
        rdt(lin_brk_pkg::A_STAT);
        chk(v, 8'h00);
        wrt(4'hC, 8'hFF);
        rdt(4'hC);
        chk(v, 8'h00);
        brk(8'h00, 8'h00, 10);
        brk(8'h10, 8'h00, 11);
        brk(8'h00, 8'h40, 13);
        wrt(lin_brk_pkg::A_CTRL3, 8'h00);
        k = node_u.n_brk;
        wrt(lin_brk_pkg::A_CTRL2, 8'h09);
        repeat (480) @(posedge clk);
        wrt(lin_brk_pkg::A_CTRL2, 8'h08);
        repeat (640) @(posedge clk);
        chk(node_u.n_brk - k, 3);
        wrt(lin_brk_pkg::A_DATA, 8'hFF);
        repeat (200) @(posedge clk);
        chk(node_u.last_low, 16);
        wrt(lin_brk_pkg::A_MASK, 8'h07);
        wrt(lin_brk_pkg::A_CTRL2, 8'h0A);
        node_u.send_byte(8'($urandom));
        rdt(lin_brk_pkg::A_STAT);
        chk(v[0], 1'b0);
        wrt(lin_brk_pkg::A_CTRL2, 8'h08);
        rdt(lin_brk_pkg::A_CTRL2);
        chk(v[1], 1'b0);
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            node_u.send_byte(b);
            chk(irq, 1'b1);
            rdt(lin_brk_pkg::A_DATA);
            chk(irq, 1'b1);
            rdt(lin_brk_pkg::A_STAT);
            chk(v[0], 1'b1);
            rdt(lin_brk_pkg::A_DATA);
            chk(v, b);
            @(posedge clk);
            chk(irq, 1'b0);
        end
        wrt(lin_brk_pkg::A_CTRL3, 8'h60);
        wrt(lin_brk_pkg::A_CTRL2, 8'h0A);
        node_u.hold(1'b0, 13);
        node_u.hold(1'b1, 60);
        chk(irq, 1'b1);
        rdt(lin_brk_pkg::A_HLEN);
        chk(v, 8'h00);
        rdt(lin_brk_pkg::A_CTRL2);
        chk(v[1], 1'b1);
        rdt(lin_brk_pkg::A_STAT);
        chk(v[2:1], 2'b10);
        rdt(lin_brk_pkg::A_DATA);
        @(posedge clk);
        chk(irq, 1'b0);
        node_u.send_byte(8'($urandom));
        rdt(lin_brk_pkg::A_STAT);
        chk(v[0], 1'b0);
        close_out();
    end
endmodule // tb_lin_sci_break_and_header_mute
